// >>> tb.sv
/*
 Self-checking bench for the fragment framer.
 Assumes the headend stand-in and the framer package.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic frame_valid = 1'b0;
    ufr_pkg::ufr_frame_t frame_desc = '0;
    logic in_valid = 1'b1;
    logic [7:0] in_byte = 8'h00;
    logic [31:0] reg_rdata;
    logic frame_busy, grant_valid, in_ready, out_valid, concat_allowed, suppression_on;
    ufr_pkg::ufr_grant_t grant;
    logic [7:0] out_byte, enc_offset, sup_offset;
    logic [23:0] sf_elem;
    int fails = 0;
    int checks_done = 0;
    ufr_framer i_ufr_framer (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .frame_valid, .frame_desc, .frame_busy, .grant_valid, .grant, .in_valid,
        .in_byte, .in_ready, .out_valid, .out_byte, .enc_offset, .concat_allowed, .sf_elem,
        .suppression_on, .sup_offset);
    ufr_headend i_ufr_headend (.clock, .reset, .out_valid, .out_byte, .grant_valid, .grant);
    always #5 clock = ~clock;
    always @(posedge clock)
        if (in_ready)
            in_byte <= in_byte + 8'h01;
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            fails++;
            $display("unexpected at %0t: %h expected %h", $time, seen, want);
        end
    endtask
    task automatic test_done;
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 check(reg_rdata, want);
    endtask
    task automatic start_frame(input logic [15:0] len, input logic km);
        @(posedge clock);
        frame_valid <= 1'b1;
        frame_desc <= {len, 8'h11, 4'h1, km, km};
        @(posedge clock);
        frame_valid <= 1'b0;
    endtask
    task automatic wait_pieces(input int n);
        for (int w = 0; w < 200 && i_ufr_headend.pieces == n; w++)
            @(posedge clock);
        #1;
        check(i_ufr_headend.pieces, n + 1);
    endtask
    task automatic frame_run(input logic priv);
        int n;
        wr(ufr_pkg::REG_SEQ, 32'h0000000e);
        wr(ufr_pkg::REG_CTRL, {16'h0, 8'h22, 4'h9, 1'b0, 1'b1, priv, 1'b1});
        start_frame(16'd40, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            n = i_ufr_headend.pieces;
            i_ufr_headend.give(16'd26, 14'h0aa5);
            @(posedge clock);
            #1 check(enc_offset, 8'h00);
            check(concat_allowed, !priv);
            wait_pieces(n);
            check(i_ufr_headend.total, 26);
            check(i_ufr_headend.hdr[0], ufr_pkg::FRAG_FC);
            check(i_ufr_headend.hdr[1], 8'h06);
            check(i_ufr_headend.hdr[4], 8'h35);
            check(i_ufr_headend.hdr[5], 8'h91);
            check(i_ufr_headend.hdr[6], {priv, 1'b0, 6'h0a});
            check(i_ufr_headend.hdr[7], 8'ha5);
            check(i_ufr_headend.hdr[8], k == 3 ? 8'h22 : 8'h11);
            check(i_ufr_headend.hdr[9], {2'b00, k == 0, k == 3, 4'(14 + k)});
        end
        check(i_ufr_headend.seq_err, 0);
        check(i_ufr_headend.crc_err, 0);
    endtask
    task automatic whole_frame;
        int r;
        wr(ufr_pkg::REG_CTRL, 32'h0);
        start_frame(16'd40, 1'b0);
        #1 check(frame_busy, 1'b1);
        r = i_ufr_headend.raw;
        i_ufr_headend.give(16'd17, 14'h0001);
        repeat (30) @(posedge clock);
        check(i_ufr_headend.raw - r, 0);
        i_ufr_headend.give(16'd40, 14'h0001);
        #1 check(enc_offset, 8'h0c);
        for (int w = 0; w < 200 && i_ufr_headend.raw != r + 40; w++)
            @(posedge clock);
        repeat (3) @(posedge clock);
        check(i_ufr_headend.raw - r, 40);
        check({frame_busy, in_ready}, 2'b00);
    endtask
    task automatic flow_elem;
        wr(ufr_pkg::REG_SF, 32'h00002f07);
        repeat (3) @(posedge clock);
        check({sf_elem, suppression_on, sup_offset}, {24'h620785, 1'b1, 8'h00});
        rd(ufr_pkg::REG_SF_ELEM, 32'h00620785);
        wr(ufr_pkg::REG_SF, 32'h0);
        repeat (3) @(posedge clock);
        check({sf_elem, suppression_on, sup_offset}, {24'h510000, 1'b0, 8'h0c});
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        fails++;
        test_done;
    end
    initial
    begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        rd(ufr_pkg::REG_STATUS, 32'h0);
        rd(ufr_pkg::REG_SF_ELEM, 32'h00510000);
        rd(8'h20, 32'h0);
        frame_run(1'b0);
        frame_run(1'b1);
        whole_frame;
        flow_elem;
        test_done;
    end
endmodule
`default_nettype wire

// >>> ufr_crc.sv
/*
 Byte-wide CRC engine, MSB first, generic polynomial and preset.
 Assumes the caller clears it before each covered span.
*/
`timescale 1ns/1ns
`default_nettype none
module ufr_crc #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] POLY = '0,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Feed
    input wire logic clear,
    input wire logic enable,
    input wire logic [7:0] data,
    // Result
    output logic [WIDTH-1:0] crc
);
    function automatic logic [WIDTH-1:0] step(input logic [WIDTH-1:0] c, input logic [7:0] d);
        logic [WIDTH-1:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
        begin
            if (r[WIDTH-1] ^ d[i])
                r = (r << 1) ^ POLY;
            else
                r = r << 1;
        end
        return r;
    endfunction

    always_ff @(posedge clock)
    begin
        if (reset || clear)
            crc <= INIT;
        else if (enable)
            crc <= step(crc, data);
    end
endmodule
`default_nettype wire

// >>> ufr_framer.sv
/*
 Upstream fragment framer: splits a frame over partial grants, adds
 the fragment header, header check and per-piece CRC.
 Assumes the payload source presents a byte whenever asked and the
 grant source never grants less than the least fragment size.
*/
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RQ1: element opens with 4-bit type, 4-bit length
// RQ2: fragment element type 3, length 5
// RQ3: key seq, version 1, enable, toggle, 14-bit id (version is the frame's ver field while privacy is on)
// RQ4: 8-bit piggyback count then two zero bits
// RQ5: first flag first piece, last flag last
// RQ6: any start sequence, then plus one, wrapping
// RQ7: headend checks sequence steps by one
// RQ8: frame control type 11, parameter 00011
// RQ9: fragment when grant shorter than request
// RQ10: last piece request asks for next frame
// RQ11: fixed header, overhead sixteen bytes total
// RQ12: privacy element always, enable cleared when off
// RQ13: identifier equals triggering partial grant's
// RQ14: separate CRC appended to each piece
// RQ15: headend grants at least seventeen bytes
// RQ16: encryption starts byte one or thirteen
// RQ17: flow element type 5/6, one-byte index
// RQ18: no element or index zero: no suppression
// RQ19: suppression starts byte one up, thirteen down
// RQ20: packet CRC covers only sent bytes
// RQ21: optional queue bit and active grant count
// RQ22: suppression rules take at least 64 bytes
// RQ23: never concatenate key messages when all enabled
// RQ24: last flag when remainder plus overhead fits
module ufr_framer #(
    parameter int SUP_SIZE = 64
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Frame descriptor
    input wire logic frame_valid,
    input wire ufr_pkg::ufr_frame_t frame_desc,
    output logic frame_busy,
    // Grant
    input wire logic grant_valid,
    input wire ufr_pkg::ufr_grant_t grant,
    // Payload in
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    output logic in_ready,
    // Burst out
    output logic out_valid,
    output logic [7:0] out_byte,
    // Side information
    output logic [7:0] enc_offset,
    output logic concat_allowed,
    output logic [23:0] sf_elem,
    output logic suppression_on,
    output logic [7:0] sup_offset
);
    ufr_pkg::ufr_ctrl_t ctrl;
    ufr_pkg::ufr_sfcfg_t sfcfg;
    ufr_pkg::ufr_status_t status;
    ufr_pkg::ufr_frame_t fr;
    ufr_pkg::ufr_state_t state, next_state;
    logic [3:0] seq_start;
    logic [3:0] hidx;
    logic [1:0] cidx;
    logic [15:0] remain;
    logic [15:0] chunk;
    logic [15:0] left;
    logic [13:0] service_flow_id;
    logic [7:0] req_f;
    logic [3:0] seq;
    logic [7:0] frag_count;
    logic first_f;
    logic last_f;
    logic frag_active;
    logic take_grant;
    logic take_byte;
    logic fits_whole;
    logic fits_last;
    logic [16:0] need_last;
    logic [15:0] next_chunk;
    logic [15:0] len_field;
    logic [3:0] ver_f;
    logic [7:0] hdr_byte;
    logic [15:0] header_check;
    logic [31:0] piece_crc;

    // Decisions on a grant
    assign take_grant = state == ufr_pkg::ST_IDLE && frame_busy && grant_valid;
    assign take_byte = in_valid && in_ready;
    assign fits_whole = !frag_active && grant.bytes >= remain;
    assign need_last = {1'b0, remain} + {1'b0, ufr_pkg::FRAG_OVERHEAD};
    assign fits_last = need_last <= {1'b0, grant.bytes}; // RQ24
    // Partial grant size is at least overhead plus one byte
    assign next_chunk = fits_last ? remain : grant.bytes - ufr_pkg::FRAG_OVERHEAD; // RQ15
    assign len_field = {8'h00, ufr_pkg::FRAG_ELEN} + chunk + ufr_pkg::CRC_BYTES;
    assign ver_f = ctrl.privacy_on ? fr.ver : ufr_pkg::ELEM_VER; // RQ12

    always_comb
    begin
        next_state = state;
        unique case (state)
            ufr_pkg::ST_IDLE:
            begin
                if (take_grant && fits_whole)
                    next_state = ufr_pkg::ST_PASS;
                else if (take_grant && (ctrl.frag_en || frag_active))
                    next_state = ufr_pkg::ST_HDR; // RQ9
            end
            ufr_pkg::ST_HDR:
            begin
                if (hidx == ufr_pkg::HDR_LAST)
                    next_state = ufr_pkg::ST_DATA;
            end
            ufr_pkg::ST_DATA:
            begin
                if (take_byte && left == 16'h0001)
                    next_state = ufr_pkg::ST_CRC;
            end
            ufr_pkg::ST_CRC:
            begin
                if (cidx == ufr_pkg::CRC_LAST)
                    next_state = ufr_pkg::ST_IDLE;
            end
            ufr_pkg::ST_PASS:
            begin
                if (take_byte && left == 16'h0001)
                    next_state = ufr_pkg::ST_IDLE;
            end
            default:
                next_state = ufr_pkg::ST_IDLE;
        endcase
    end

    // Fragment header, one byte per index
    always_comb
    begin
        unique case (hidx)
            4'h0: hdr_byte = ufr_pkg::FRAG_FC; // RQ8
            4'h1: hdr_byte = ufr_pkg::FRAG_ELEN; // RQ11
            4'h2: hdr_byte = len_field[15:8];
            4'h3: hdr_byte = len_field[7:0];
            4'h4: hdr_byte = {ufr_pkg::PRIV_TYPE, ufr_pkg::FRAG_VLEN}; // RQ1 RQ2
            4'h5: hdr_byte = {ctrl.key_seq, ver_f}; // RQ3
            4'h6: hdr_byte = {ctrl.privacy_on, ctrl.toggle, service_flow_id[13:8]}; // RQ12
            4'h7: hdr_byte = service_flow_id[7:0];
            4'h8: hdr_byte = req_f; // RQ4
            4'h9: hdr_byte = {ufr_pkg::RESV_ZERO, first_f, last_f, seq}; // RQ5
            4'ha: hdr_byte = ~header_check[15:8];
            4'hb: hdr_byte = ~header_check[7:0];
            default: hdr_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            state <= ufr_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge clock)
    begin
        if (reset || state != ufr_pkg::ST_HDR)
            hidx <= 4'h0;
        else
            hidx <= hidx + 4'h1;
    end

    always_ff @(posedge clock)
    begin
        if (reset || state != ufr_pkg::ST_CRC)
            cidx <= 2'h0;
        else
            cidx <= cidx + 2'h1;
    end

    // Frame ownership and progress
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            frame_busy <= 1'b0;
            fr <= '0;
            remain <= 16'h0000;
        end
        else if (!frame_busy && frame_valid)
        begin
            frame_busy <= 1'b1;
            fr <= frame_desc;
            remain <= frame_desc.len;
        end
        else
        begin
            if (take_byte)
                remain <= remain - 16'h0001;
            if ((state == ufr_pkg::ST_CRC && cidx == ufr_pkg::CRC_LAST && last_f)
                || (state == ufr_pkg::ST_PASS && take_byte && left == 16'h0001))
                frame_busy <= 1'b0;
        end
    end

    // Per-fragment fields, fixed at the grant
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            chunk <= 16'h0000;
            left <= 16'h0000;
            service_flow_id <= '0;
            req_f <= 8'h00;
            seq <= 4'h0;
            first_f <= 1'b0;
            last_f <= 1'b0;
            frag_active <= 1'b0;
            frag_count <= 8'h00;
        end
        else if (take_grant && next_state == ufr_pkg::ST_PASS)
            left <= remain;
        else if (take_grant && next_state == ufr_pkg::ST_HDR)
        begin
            chunk <= next_chunk;
            left <= next_chunk;
            service_flow_id <= grant.service_flow_id; // RQ13
            req_f <= fits_last ? ctrl.next_req : fr.req; // RQ10
            seq <= frag_active ? seq + 4'h1 : seq_start; // RQ6
            first_f <= !frag_active; // RQ5
            last_f <= fits_last; // RQ24
            frag_active <= 1'b1;
            frag_count <= frag_count + 8'h01;
        end
        else
        begin
            if (take_byte)
                left <= left - 16'h0001;
            if (state == ufr_pkg::ST_CRC && cidx == ufr_pkg::CRC_LAST && last_f)
                frag_active <= 1'b0;
        end
    end

    // Header check and piece CRC
    ufr_crc #(
        .WIDTH(16),
        .POLY(ufr_pkg::CRC16_POLY),
        .INIT(ufr_pkg::CRC16_INIT)
    ) u_hcs (
        .clock(clock),
        .reset(reset),
        .clear(take_grant),
        .enable(state == ufr_pkg::ST_HDR && hidx < ufr_pkg::HCS_HI),
        .data(hdr_byte),
        .crc(header_check)
    );

    // Only bytes actually sent are covered, one CRC per piece
    ufr_crc #(
        .WIDTH(32),
        .POLY(ufr_pkg::CRC32_POLY),
        .INIT(ufr_pkg::CRC32_INIT)
    ) u_piece_crc (
        .clock(clock),
        .reset(reset),
        .clear(take_grant), // RQ14
        .enable(state == ufr_pkg::ST_DATA && take_byte), // RQ20
        .data(in_byte),
        .crc(piece_crc)
    );

    ufr_sf_elem #(
        .SUP_SIZE(SUP_SIZE)
    ) u_sf (
        .clock(clock),
        .reset(reset),
        .cfg(sfcfg),
        .elem(sf_elem),
        .suppression_on(suppression_on),
        .sup_offset(sup_offset)
    );

    // Burst output
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            out_valid <= 1'b0;
            out_byte <= 8'h00;
            in_ready <= 1'b0;
        end
        else
        begin
            in_ready <= next_state == ufr_pkg::ST_DATA || next_state == ufr_pkg::ST_PASS;
            out_valid <= state == ufr_pkg::ST_HDR || state == ufr_pkg::ST_CRC || take_byte;
            if (state == ufr_pkg::ST_HDR)
                out_byte <= hdr_byte;
            else if (state == ufr_pkg::ST_CRC)
                out_byte <= ~piece_crc[8 * (3 - cidx) +: 8]; // RQ14
            else if (take_byte)
                out_byte <= in_byte;
        end
    end

    // Side information
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            enc_offset <= ufr_pkg::OFS_THIRTEENTH;
            concat_allowed <= 1'b0;
        end
        else
        begin
            enc_offset <= (frag_active || state == ufr_pkg::ST_HDR) ? ufr_pkg::OFS_FIRST
                : ufr_pkg::OFS_THIRTEENTH; // RQ16
            concat_allowed <= fr.concat && ctrl.concat_en && !(ctrl.frag_en
                && ctrl.privacy_on && fr.key_mgmt); // RQ23
        end
    end

    // Register port
    assign status = '{frag_count: frag_count, seq: seq, resv: 2'h0,
        frag_active: frag_active, busy: frame_busy};

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ctrl <= ufr_pkg::CTRL_RST;
            sfcfg <= ufr_pkg::SF_RST;
            seq_start <= ufr_pkg::SEQ_RST;
        end
        else if (reg_write)
        begin
            if (reg_addr == ufr_pkg::REG_CTRL)
                ctrl <= ufr_pkg::ufr_ctrl_t'(reg_wdata[$bits(ufr_pkg::ufr_ctrl_t)-1:0]);
            if (reg_addr == ufr_pkg::REG_SF)
                sfcfg <= ufr_pkg::ufr_sfcfg_t'(reg_wdata[$bits(ufr_pkg::ufr_sfcfg_t)-1:0]);
            if (reg_addr == ufr_pkg::REG_SEQ)
                seq_start <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset || !reg_read)
            reg_rdata <= 32'h0000_0000;
        else
        begin
            unique case (reg_addr)
                ufr_pkg::REG_CTRL: reg_rdata <= 32'(ctrl);
                ufr_pkg::REG_SF: reg_rdata <= 32'(sfcfg);
                ufr_pkg::REG_STATUS: reg_rdata <= 32'(status);
                ufr_pkg::REG_SEQ: reg_rdata <= 32'(seq_start);
                ufr_pkg::REG_SF_ELEM: reg_rdata <= 32'(sf_elem);
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // Checking helpers
    logic [3:0] seq_prev;
    logic [15:0] fcnt;
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            seq_prev <= 4'h0;
            fcnt <= 16'h0000;
        end
        else
        begin
            if (state == ufr_pkg::ST_CRC && cidx == ufr_pkg::CRC_LAST)
                seq_prev <= seq;
            if (take_grant)
                fcnt <= 16'h0000;
            else if (state == ufr_pkg::ST_HDR || state == ufr_pkg::ST_CRC || take_byte)
                fcnt <= fcnt + 16'h0001;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence s_hdr(logic [3:0] n);
        state == ufr_pkg::ST_HDR && hidx == n;
    endsequence
    sequence s_crc_end;
        state == ufr_pkg::ST_CRC && cidx == ufr_pkg::CRC_LAST;
    endsequence

    a_fc_code: assert property (s_hdr(4'h0) |=> out_valid && out_byte == ufr_pkg::FRAG_FC) // RQ8
        else $error("fragment frame control wrong");
    a_elem_head: assert property (s_hdr(4'h4) |=> out_byte == 8'h35) // RQ2
        else $error("fragment element head wrong");
    a_ver_fixed: assert property (s_hdr(4'h5) ##0 !ctrl.privacy_on |=> out_byte[3:0] == 4'h1) // RQ3
        else $error("element version wrong");
    a_resv_zero: assert property (s_hdr(4'h9) |=> out_byte[7:6] == 2'b00) // RQ4
        else $error("reserved bits not zero");
    a_last_flag: assert property (s_hdr(4'h9) |=> out_byte[4] == $past(chunk == remain)) // RQ5
        else $error("last flag disagrees with remainder");
    a_seq_step: assert property (s_hdr(4'h9) ##0 !first_f |=> out_byte[3:0] == 4'(seq_prev + 4'h1)) // RQ6
        else $error("sequence did not step by one");
    a_frag_start: assert property (take_grant && ctrl.frag_en && !frag_active // RQ9
        && grant.bytes < remain |=> state == ufr_pkg::ST_HDR)
        else $error("short grant did not start fragmenting");
    a_sid_match: assert property (take_grant && next_state == ufr_pkg::ST_HDR // RQ13
        |-> ##8 out_byte[5:0] == $past(grant.service_flow_id[13:8], 8))
        else $error("fragment identifier differs from grant");
    a_overhead: assert property (s_crc_end |-> fcnt + 16'h0001 == chunk + 16'h0010) // RQ11
        else $error("fragment overhead not sixteen bytes");
    a_crc_first: assert property (state == ufr_pkg::ST_CRC && cidx == 2'h0 // RQ14
        |=> out_valid && out_byte == ~$past(piece_crc[31:24]))
        else $error("piece CRC byte wrong");
    a_enc_start: assert property (state == ufr_pkg::ST_HDR |=> enc_offset == 8'h00) // RQ16
        else $error("encryption offset wrong while fragmenting");
    a_key_mgmt: assert property (ctrl.frag_en && ctrl.concat_en && ctrl.privacy_on // RQ23
        && fr.key_mgmt |=> !concat_allowed)
        else $error("key message allowed into concatenation");
endmodule
`default_nettype wire

// >>> ufr_headend.sv
/*
 Headend stand-in: issues grants and parses returned fragments.
 Assumes the framer byte stream and one shared clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ufr_headend (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Burst from the framer
    input wire logic out_valid,
    input wire logic [7:0] out_byte,
    // Grant to the framer
    output logic grant_valid,
    output ufr_pkg::ufr_grant_t grant
);
    logic [7:0] hdr [0:11];
    logic [3:0] seq_prev;
    int idx;
    int total;
    int pieces;
    int raw;
    int seq_err;
    int crc_err;
    logic [31:0] hcs_run;
    logic [31:0] piece_crc_run;
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d,
        input logic [31:0] poly, input int top);
        for (int i = 7; i >= 0; i--)
            c = (c[top] ^ d[i]) ? (c << 1) ^ poly : c << 1;
        return c;
    endfunction
    initial
    begin
        grant_valid = 1'b0;
        grant = '0;
    end
    task automatic give(input logic [15:0] n, input logic [13:0] service_flow_id);
        @(posedge clock);
        grant_valid <= 1'b1;
        grant <= {(n < 16'd17) ? 16'd17 : n, service_flow_id};
        @(posedge clock);
        grant_valid <= 1'b0;
        grant <= ~grant;
    endtask
    always @(posedge clock)
        if (reset)
        begin
            idx <= 0;
            pieces <= 0;
            raw <= 0;
            seq_err <= 0;
            crc_err <= 0;
        end
        else if (out_valid)
        begin
            if (idx == 0 && out_byte !== ufr_pkg::FRAG_FC)
                raw <= raw + 1;
            else
            begin
                if (idx < 12)
                    hdr[idx] <= out_byte;
                if (idx == 3)
                    total <= {hdr[2], out_byte} + 6;
                // Own reference sums over header and payload
                if (idx < 10)
                    hcs_run <= crc_byte(idx == 0 ? 32'(ufr_pkg::CRC16_INIT) : hcs_run, out_byte,
                        32'(ufr_pkg::CRC16_POLY), 15);
                else if (idx < 12 && out_byte !== ~hcs_run[8 * (11 - idx) +: 8])
                    crc_err <= crc_err + 1;
                else if (idx > 11 && idx + 4 < total)
                    piece_crc_run <= crc_byte(idx == 12 ? ufr_pkg::CRC32_INIT : piece_crc_run, out_byte,
                        ufr_pkg::CRC32_POLY, 31);
                else if (idx > 11 && out_byte !== ~piece_crc_run[8 * (total - 1 - idx) +: 8])
                    crc_err <= crc_err + 1;
                if (idx == 9)
                begin
                    // First flag restarts, others step by one
                    if (!out_byte[5] && out_byte[3:0] !== seq_prev + 4'h1)
                        seq_err <= seq_err + 1;
                    seq_prev <= out_byte[3:0];
                end
                idx <= (idx > 11 && idx + 1 == total) ? 0 : idx + 1;
                if (idx > 11 && idx + 1 == total)
                    pieces <= pieces + 1;
            end
        end
endmodule
`default_nettype wire

// >>> ufr_pkg.sv
/*
 Constants, carriers and states for the upstream fragment framer.
 Assumes one byte-stream clock shared by every user of the package.
*/
`default_nettype none
package ufr_pkg;
    localparam logic [7:0] FRAG_FC = 8'hc7;
    localparam logic [7:0] FRAG_ELEN = 8'h06;
    localparam logic [3:0] PRIV_TYPE = 4'h3;
    localparam logic [3:0] FRAG_VLEN = 4'h5;
    localparam logic [3:0] ELEM_VER = 4'h1;
    localparam logic [1:0] RESV_ZERO = 2'h0;
    localparam logic [15:0] CRC_BYTES = 16'h0004;
    localparam logic [15:0] FRAG_OVERHEAD = 16'h0010;
    localparam logic [3:0] HCS_HI = 4'ha;
    localparam logic [3:0] HDR_LAST = 4'hb;
    localparam logic [1:0] CRC_LAST = 2'h3;
    localparam logic [3:0] SF_TYPE_DN = 4'h5;
    localparam logic [3:0] SF_TYPE_UP = 4'h6;
    localparam logic [3:0] SF_LEN_ONE = 4'h1;
    localparam logic [3:0] SF_LEN_TWO = 4'h2;
    localparam logic [7:0] NO_SUPPRESS = 8'h00;
    localparam logic [7:0] OFS_FIRST = 8'h00;
    localparam logic [7:0] OFS_THIRTEENTH = 8'h0c;
    localparam int MIN_SUP_SIZE = 64;
    localparam logic [15:0] CRC16_POLY = 16'h1021;
    localparam logic [15:0] CRC16_INIT = 16'hffff;
    localparam logic [31:0] CRC32_POLY = 32'h04c11db7;
    localparam logic [31:0] CRC32_INIT = 32'hffffffff;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SF = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_SEQ = 8'h0c;
    localparam logic [7:0] REG_SF_ELEM = 8'h10;
    typedef struct packed {
        logic [7:0] next_req;
        logic [3:0] key_seq;
        logic toggle;
        logic concat_en;
        logic privacy_on;
        logic frag_en;
    } ufr_ctrl_t;
    typedef struct packed {
        logic [6:0] active_grants;
        logic queue_ind;
        logic ugs_on;
        logic upstream;
        logic [7:0] suppression_index;
    } ufr_sfcfg_t;
    typedef struct packed {
        logic [7:0] frag_count;
        logic [3:0] seq;
        logic [1:0] resv;
        logic frag_active;
        logic busy;
    } ufr_status_t;
    typedef struct packed {
        logic [15:0] len;
        logic [7:0] req;
        logic [3:0] ver;
        logic key_mgmt;
        logic concat;
    } ufr_frame_t;
    typedef struct packed {
        logic [15:0] bytes;
        logic [13:0] service_flow_id;
    } ufr_grant_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HDR = 3'b001,
        ST_DATA = 3'b010,
        ST_CRC = 3'b011,
        ST_PASS = 3'b100
    } ufr_state_t;
    localparam ufr_ctrl_t CTRL_RST = '0;
    localparam ufr_sfcfg_t SF_RST = '0;
    localparam logic [3:0] SEQ_RST = 4'h0;
endpackage
`default_nettype wire

// >>> ufr_sf_elem.sv
/*
 Service-flow element builder: suppression index and grant sync byte.
 Assumes configuration is held steady by software between packets.
*/
`timescale 1ns/1ns
`default_nettype none
module ufr_sf_elem #(
    parameter int SUP_SIZE = 64
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Configuration
    input wire ufr_pkg::ufr_sfcfg_t cfg,
    // Element and suppression view
    output logic [23:0] elem,
    output logic suppression_on,
    output logic [7:0] sup_offset
);
    logic [3:0] ext_elem_type;
    logic [3:0] ext_elem_len;
    assign ext_elem_type = cfg.upstream ? ufr_pkg::SF_TYPE_UP : ufr_pkg::SF_TYPE_DN;
    assign ext_elem_len = (cfg.upstream && cfg.ugs_on) ? ufr_pkg::SF_LEN_TWO
        : ufr_pkg::SF_LEN_ONE;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            elem <= '0;
            suppression_on <= 1'b0;
            sup_offset <= ufr_pkg::OFS_FIRST;
        end
        else
        begin
            elem <= {ext_elem_type, ext_elem_len, cfg.suppression_index,
                cfg.queue_ind, cfg.active_grants}; // RQ17 RQ21
            suppression_on <= cfg.suppression_index != ufr_pkg::NO_SUPPRESS; // RQ18
            sup_offset <= cfg.upstream ? ufr_pkg::OFS_FIRST : ufr_pkg::OFS_THIRTEENTH; // RQ19
        end
    end

    a_sup_size: assert property (@(posedge clock) SUP_SIZE >= ufr_pkg::MIN_SUP_SIZE) // RQ22
        else $error("suppression size below minimum");
    a_sup_off: assert property (@(posedge clock) disable iff (reset) // RQ18
        cfg.suppression_index == ufr_pkg::NO_SUPPRESS |=> !suppression_on)
        else $error("suppression on with index zero");
endmodule
`default_nettype wire
